// *** prog_access_pkg.sv ***
// Constants and types shared by the program space data access block.
// Assumes a 32-bit APB register bus and a 24-bit wide program array.
package prog_access_pkg;

    // ************************************************************
    // Register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [11:0] OFS_TABLE_PAGE   = 12'h000;
    localparam logic [11:0] OFS_WINDOW_PAGE  = 12'h004;
    localparam logic [11:0] OFS_CORE_CONTROL = 12'h008;
    localparam logic [11:0] OFS_STATUS       = 12'h00c;

    localparam logic [7:0]  RST_TABLE_PAGE   = 8'h00;
    localparam logic [7:0]  RST_WINDOW_PAGE  = 8'h00;
    localparam logic [7:0]  RST_CORE_CONTROL = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int WINDOW_ENABLE_BIT = 2;
    localparam int CONFIG_SPACE_BIT  = 7;
    localparam int EA_MSB            = 15;
    localparam int STATUS_BUSY_BIT   = 31;
    localparam int STATUS_PAGE_LSB   = 17;

    // ************************************************************
    // Array geometry, in instructions per row and per erase page
    // ************************************************************
    localparam int ROW_WORDS  = 64;
    localparam int PAGE_WORDS = 512;
    localparam int ROW_SHIFT  = $clog2(ROW_WORDS) + 1;
    localparam int PAGE_SHIFT = $clog2(PAGE_WORDS) + 1;
    localparam int ROW_W      = 24 - ROW_SHIFT;
    localparam int PAGE_W     = 24 - PAGE_SHIFT;

    // ************************************************************
    // Extra instruction cycles for a window access
    // ************************************************************
    localparam logic [1:0] EXTRA_NONE = 2'd0;
    localparam logic [1:0] EXTRA_COPY = 2'd1;
    localparam logic [1:0] EXTRA_FULL = 2'd2;

    // ************************************************************
    // Byte lanes of a program word
    // ************************************************************
    localparam logic [2:0] BE_NONE   = 3'b000;
    localparam logic [2:0] BE_LOW    = 3'b001;
    localparam logic [2:0] BE_MID    = 3'b010;
    localparam logic [2:0] BE_WORD   = 3'b011;
    localparam logic [2:0] BE_HIGH   = 3'b100;

    typedef enum logic [2:0] {
        op_data_read,
        op_table_read_low,
        op_table_read_high,
        op_table_write_low,
        op_table_write_high
    } op_e;

endpackage : prog_access_pkg

// *** table_read_format.sv ***
// Read data steering for table reads of the low word and high byte.
// Assumes a registered program word at its input.
`timescale 1ns/1ns
`default_nettype none
module table_read_format (
    input  wire logic        high_space,
    input  wire logic        byte_mode,
    input  wire logic        byte_sel,
    input  wire logic [23:0] word,
    output logic      [15:0] data
);
    always_comb begin
        data = 16'h0000;
        if (!high_space) begin
            // [RULE_01] [RULE_02] low word steering
            if (!byte_mode) begin
                data = word[15:0];
            end else if (byte_sel) begin
                data = {8'h00, word[15:8]};
            end else begin
                data = {8'h00, word[7:0]};
            end
        end else begin
            // [RULE_03] [RULE_04] phantom byte is zero
            if (!byte_mode || !byte_sel) begin
                data = {8'h00, word[23:16]};
            end else begin
                data = 16'h0000;
            end
        end
    end
endmodule : table_read_format
`default_nettype wire

// *** prog_space_access.sv ***
// Program space data access: table reads and writes, visibility window.
// Assumes requests held until core_ack; array reads answer at once.
// How it works
// [RULE_01] Word table read low returns bits 15:0
// [RULE_02] Byte read low picks byte by select
// [RULE_03] Word read high: bits 23:16, upper zero
// [RULE_04] Byte read high; phantom byte reads zero
// [RULE_05] Only high operations touch bits 23:16
// [RULE_06] Addresses step two per program word
// [RULE_07] Table page bit 7 selects configuration
// [RULE_08] Table page above effective address
// [RULE_09] Window needs address bit 15 and enable
// [RULE_10] Window page plus 15 address bits
// [RULE_11] Program bit 15 from window page bit 0
// [RULE_12] Window reads return low 16 bits
// [RULE_13] Window read costs two array fetches
// [RULE_14] Window off during table operations
// [RULE_15] Copy adds one cycle, others two
// [RULE_16] Repeat loop: two on edges, else none
// [RULE_17] Software fills window constants' upper byte
// [RULE_18] Rows of 64, pages of 512 words
// [RULE_19] Page registers 8 bits, reset zero
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module prog_space_access (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic      [31:0]           prdata,
    output logic                       pslverr,
    // Core side
    input  wire logic                  core_req,
    input  wire prog_access_pkg::op_e  core_op,
    input  wire logic                  core_byte,
    input  wire logic [15:0]           core_addr,
    input  wire logic [15:0]           core_wdata,
    input  wire logic                  core_copy,
    input  wire logic                  core_in_repeat,
    input  wire logic                  core_rpt_edge,
    output logic                       core_busy,
    output logic                       core_ack,
    output logic      [15:0]           core_rdata,
    output logic                       core_window_hit,
    output logic      [1:0]            core_extra,
    // Program array side
    output logic                       flash_req,
    output logic                       flash_we,
    output logic      [2:0]            flash_be,
    output logic      [23:0]           flash_addr,
    output logic      [23:0]           flash_wdata,
    output logic                       flash_cfg,
    input  wire logic [23:0]           flash_rdata
);
    import prog_access_pkg::*;

    typedef enum logic [2:0] {
        st_idle, st_tbl_rd, st_win1, st_win2, st_hold, st_done
    } state_e;

    state_e             state_r;
    logic [7:0]         table_page_r;
    logic [7:0]         window_page_r;
    logic [7:0]         core_control_r;
    logic               high_r;
    logic               byte_r;
    logic               bsel_r;
    logic [1:0]         hold_r;
    logic [ROW_W-1:0]   row_r;
    logic [PAGE_W-1:0]  page_r;
    logic [15:0]        fmt_data;
    logic               take;
    logic               table_op;
    logic               tbl_busy;
    logic               win_hit;
    logic [1:0]         extra_nxt;
    logic [23:0]        tbl_addr;
    logic               apb_acc;

    // ************************************************************
    // Request decode
    // ************************************************************
    assign take     = core_req && !core_busy && (state_r == st_idle);
    assign table_op = (core_op != op_data_read);
    assign tbl_busy = (state_r == st_tbl_rd) || high_r && core_busy;
    // [RULE_08] [RULE_06] page over byte address
    assign tbl_addr = {table_page_r, core_addr[15:1], 1'b0};

    // [RULE_09] [RULE_14] window hit qualification
    assign win_hit = (core_op == op_data_read) && core_addr[EA_MSB]
                     && core_control_r[WINDOW_ENABLE_BIT] && !tbl_busy;

    always_comb begin
        extra_nxt = EXTRA_FULL;
        if (core_in_repeat) begin
            // [RULE_16] repeat loop cost
            extra_nxt = core_rpt_edge ? EXTRA_FULL : EXTRA_NONE;
        end else if (core_copy) begin
            // [RULE_15] copy instruction cost
            extra_nxt = EXTRA_COPY;
        end
    end

    table_read_format u_fmt (
        .high_space (high_r),
        .byte_mode  (byte_r),
        .byte_sel   (bsel_r),
        .word       (flash_rdata),
        .data       (fmt_data)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= st_idle;
            hold_r  <= 2'd0;
        end else if (ce) begin
            case (state_r)
                st_idle: begin
                    if (take) begin
                        if (core_op == op_table_read_low
                            || core_op == op_table_read_high) begin
                            state_r <= st_tbl_rd;
                        end else if (win_hit) begin
                            state_r <= st_win1;
                        end else begin
                            state_r <= st_done;
                        end
                    end
                end
                st_tbl_rd: state_r <= st_done;
                // [RULE_13] second array fetch
                st_win1:   state_r <= st_win2;
                st_win2: begin
                    hold_r  <= core_extra;
                    state_r <= (core_extra > EXTRA_COPY) ? st_hold : st_done;
                end
                st_hold: begin
                    hold_r  <= hold_r - 2'd1;
                    if (hold_r <= 2'd2) begin
                        state_r <= st_done;
                    end
                end
                st_done:   state_r <= st_idle;
                default:   state_r <= st_idle;
            endcase
        end
    end

    // ************************************************************
    // Core handshake and read data
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_busy       <= 1'b0;
            core_ack        <= 1'b0;
            core_rdata      <= 16'h0000;
            core_window_hit <= 1'b0;
            core_extra      <= EXTRA_NONE;
            high_r          <= 1'b0;
            byte_r          <= 1'b0;
            bsel_r          <= 1'b0;
        end else if (ce) begin
            core_ack <= (state_r == st_done);
            if (take) begin
                core_busy       <= 1'b1;
                core_window_hit <= win_hit;
                core_extra      <= win_hit ? extra_nxt : EXTRA_NONE;
                high_r          <= (core_op == op_table_read_high)
                                   || (core_op == op_table_write_high);
                byte_r          <= core_byte;
                bsel_r          <= core_addr[0];
                if (!table_op && !win_hit) begin
                    core_rdata <= 16'h0000;
                end
            end else if (core_ack) begin
                core_busy <= 1'b0;
            end
            if (state_r == st_tbl_rd) begin
                core_rdata <= fmt_data;
            end
            if (state_r == st_win2) begin
                // [RULE_12] low word only
                core_rdata <= flash_rdata[15:0];
            end
        end
    end

    // ************************************************************
    // Program array port
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_req   <= 1'b0;
            flash_we    <= 1'b0;
            flash_be    <= BE_NONE;
            flash_addr  <= 24'h000000;
            flash_wdata <= 24'h000000;
            flash_cfg   <= 1'b0;
        end else if (ce) begin
            flash_req <= 1'b0;
            flash_we  <= 1'b0;
            if (take && table_op) begin
                flash_req  <= 1'b1;
                flash_addr <= tbl_addr;
                // [RULE_07] configuration space select
                flash_cfg  <= table_page_r[CONFIG_SPACE_BIT];
                flash_we   <= (core_op == op_table_write_low)
                              || (core_op == op_table_write_high);
                flash_be   <= BE_NONE;
                // [RULE_05] lane selection per space
                if (core_op == op_table_write_low) begin
                    flash_wdata <= {8'h00, core_wdata};
                    if (!core_byte) begin
                        flash_be <= BE_WORD;
                    end else if (core_addr[0]) begin
                        flash_be    <= BE_MID;
                        flash_wdata <= {8'h00, core_wdata[7:0], 8'h00};
                    end else begin
                        flash_be <= BE_LOW;
                    end
                end else if (core_op == op_table_write_high) begin
                    flash_wdata <= {core_wdata[7:0], 16'h0000};
                    if (!core_byte || !core_addr[0]) begin
                        flash_be <= BE_HIGH;
                    end
                end
            end else if (take && win_hit) begin
                flash_req  <= 1'b1;
                flash_be   <= BE_NONE;
                flash_cfg  <= 1'b0;
                // [RULE_10] [RULE_11] window address
                flash_addr <= {1'b0, window_page_r, core_addr[14:0]};
            end else if (state_r == st_win1) begin
                flash_req <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Row and page of the last table write
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_r  <= '0;
            page_r <= '0;
        end else if (ce && take && (core_op == op_table_write_low
                                    || core_op == op_table_write_high)) begin
            // [RULE_18] row and page indices
            row_r  <= tbl_addr[23:ROW_SHIFT];
            page_r <= tbl_addr[23:PAGE_SHIFT];
        end
    end

    // ************************************************************
    // APB registers
    // ************************************************************
    assign apb_acc = psel && penable && !pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_page_r   <= RST_TABLE_PAGE;
            window_page_r  <= RST_WINDOW_PAGE;
            core_control_r <= RST_CORE_CONTROL;
        end else if (ce && psel && penable && pready && pwrite) begin
            // [RULE_19] page registers
            if (paddr == OFS_TABLE_PAGE) begin
                table_page_r <= pwdata[7:0];
            end else if (paddr == OFS_WINDOW_PAGE) begin
                window_page_r <= pwdata[7:0];
            end else if (paddr == OFS_CORE_CONTROL) begin
                core_control_r <= pwdata[7:0] & 8'h04;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= apb_acc;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (apb_acc) begin
                if (paddr == OFS_TABLE_PAGE) begin
                    prdata <= {24'h000000, table_page_r};
                end else if (paddr == OFS_WINDOW_PAGE) begin
                    prdata <= {24'h000000, window_page_r};
                end else if (paddr == OFS_CORE_CONTROL) begin
                    prdata <= {24'h000000, core_control_r};
                end else if (paddr == OFS_STATUS) begin
                    prdata[STATUS_BUSY_BIT] <= core_busy;
                    prdata[STATUS_PAGE_LSB +: PAGE_W] <= page_r;
                    prdata[ROW_W-1:0] <= row_r;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Assertions (checked while ce is high)
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence s_win_take;
        take && win_hit;
    endsequence
    sequence s_two_fetch;
        flash_req ##1 flash_req;
    endsequence

    property p_rd_low_word;
        state_r == st_tbl_rd && !high_r && !byte_r
        |=> core_rdata == $past(flash_rdata[15:0]);
    endproperty
    a_rd_low_word: assert property (p_rd_low_word) // [RULE_01]
        else $error("read low word data wrong");

    property p_rd_low_byte;
        state_r == st_tbl_rd && !high_r && byte_r && bsel_r
        |=> core_rdata == {8'h00, $past(flash_rdata[15:8])};
    endproperty
    a_rd_low_byte: assert property (p_rd_low_byte) // [RULE_02]
        else $error("read low byte select wrong");

    property p_rd_high_word;
        state_r == st_tbl_rd && high_r && !byte_r
        |=> core_rdata == {8'h00, $past(flash_rdata[23:16])};
    endproperty
    a_rd_high_word: assert property (p_rd_high_word) // [RULE_03]
        else $error("read high word data wrong");

    property p_rd_phantom;
        state_r == st_tbl_rd && high_r && byte_r && bsel_r
        |=> core_rdata == 16'h0000;
    endproperty
    a_rd_phantom: assert property (p_rd_phantom) // [RULE_04]
        else $error("phantom byte not zero");

    property p_low_lanes;
        take && core_op == op_table_write_low |=> !flash_be[2];
    endproperty
    a_low_lanes: assert property (p_low_lanes) // [RULE_05]
        else $error("low write touched upper byte");

    property p_tbl_addr;
        take && table_op |=> flash_addr
            == {$past(table_page_r), $past(core_addr[15:1]), 1'b0}
            && flash_cfg == $past(table_page_r[CONFIG_SPACE_BIT]);
    endproperty
    a_tbl_addr: assert property (p_tbl_addr) // [RULE_08]
        else $error("table address or space wrong");

    property p_no_hit;
        take && core_op == op_data_read
        && !(core_addr[EA_MSB] && core_control_r[WINDOW_ENABLE_BIT])
        |=> !flash_req && !core_window_hit;
    endproperty
    a_no_hit: assert property (p_no_hit) // [RULE_09]
        else $error("window used without enable");

    property p_win_addr;
        s_win_take |=> flash_addr
            == {1'b0, $past(window_page_r), $past(core_addr[14:0])};
    endproperty
    a_win_addr: assert property (p_win_addr) // [RULE_10]
        else $error("window address wrong");

    property p_two_fetch;
        s_win_take |=> s_two_fetch;
    endproperty
    a_two_fetch: assert property (p_two_fetch) // [RULE_13]
        else $error("window read not two fetches");

    property p_win_data;
        state_r == st_win2 |=> core_rdata == $past(flash_rdata[15:0]);
    endproperty
    a_win_data: assert property (p_win_data) // [RULE_12]
        else $error("window data not low word");

    property p_copy_cost;
        take && win_hit && !core_in_repeat && core_copy
        |=> core_extra == EXTRA_COPY;
    endproperty
    a_copy_cost: assert property (p_copy_cost) // [RULE_15]
        else $error("copy window cost wrong");

    property p_rpt_cost;
        take && win_hit && core_in_repeat && !core_rpt_edge
        |=> core_extra == EXTRA_NONE ##[3:4] core_ack;
    endproperty
    a_rpt_cost: assert property (p_rpt_cost) // [RULE_16]
        else $error("repeat window cost wrong");

endmodule : prog_space_access
`default_nettype wire

// *** flash_array_model.sv ***
// Program array partner model: answers each read request with a word
// that is a fixed function of the address and flash_cfg. Assumes pclk is the core clock.
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    input  wire logic        pclk,
    input  wire logic        flash_req,
    input  wire logic        flash_we,
    input  wire logic [23:0] flash_addr,
    input  wire logic        flash_cfg,
    output logic      [23:0] flash_rdata
);
    logic [23:0] w;
    assign w = flash_addr ^ {flash_addr[15:0], flash_addr[23:16]}
               ^ {flash_cfg, 23'h000000} ^ 24'ha5c3e1;
    // Inverse word when not asked, so a late sample shows
    assign flash_rdata = (flash_req && !flash_we) ? w : ~w;
endmodule : flash_array_model
`default_nettype wire

// *** program_space_data_access_test.sv ***
// Self-checking bench for the program space data access block.
// Assumes the package is compiled first.
`timescale 1ns/1ns
`default_nettype none
module program_space_data_access_test;
    import prog_access_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        core_req, core_byte, core_copy, core_in_repeat, b;
    logic        core_rpt_edge, core_busy, core_ack, core_window_hit;
    logic        flash_req, flash_we, flash_cfg, err, fc, hit;
    op_e         core_op, op;
    logic [15:0] core_addr, core_wdata, core_rdata, rnd, ea, m;
    logic [1:0]  core_extra, ex;
    logic [2:0]  flash_be, be, xbe;
    logic [23:0] flash_addr, flash_wdata, flash_rdata, fa, fw, w;
    logic [7:0]  pg;
    int          failures, cmp_count, n, nreq, i;

    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    prog_space_access i_prog_space_access (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .core_req(core_req), .core_op(core_op),
        .core_byte(core_byte), .core_addr(core_addr),
        .core_wdata(core_wdata), .core_copy(core_copy),
        .core_in_repeat(core_in_repeat), .core_rpt_edge(core_rpt_edge),
        .core_busy(core_busy), .core_ack(core_ack),
        .core_rdata(core_rdata), .core_window_hit(core_window_hit),
        .core_extra(core_extra), .flash_req(flash_req),
        .flash_we(flash_we), .flash_be(flash_be),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_cfg(flash_cfg), .flash_rdata(flash_rdata));

    flash_array_model i_flash_array_model (
        .pclk(pclk), .flash_req(flash_req), .flash_we(flash_we),
        .flash_addr(flash_addr), .flash_cfg(flash_cfg),
        .flash_rdata(flash_rdata));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [23:0] word_at(input logic [23:0] x);
        return x ^ 24'ha5c3e1 ^ {x[15:0], x[23:16]} ^ {x[23], 23'h000000};
    endfunction : word_at

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_data

    task automatic check_lat(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_lat

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic run(input op_e o, input logic bm, input logic [15:0] a,
                       input logic [15:0] d);
        int k = 0;
        n = 0;
        nreq = 0;
        core_req <= 1'b1;
        core_op <= o;
        core_byte <= bm;
        core_addr <= a;
        core_wdata <= d;
        do begin
            @(posedge pclk);
            n++;
            if (flash_req === 1'b1) begin
                nreq++;
                fa = flash_addr;
                fc = flash_cfg;
                be = flash_be;
                fw = flash_wdata;
            end
        end while (core_ack !== 1'b1 && n < 30);
        core_req <= 1'b0;
        do begin
            @(posedge pclk);
            k++;
        end while (core_busy !== 1'b0 && k < 30);
    endtask : run

    initial begin
        failures = 0;
        cmp_count = 0;
        rnd = 16'h0017;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {core_req, core_byte, core_addr, core_wdata} = '0;
        {core_copy, core_in_repeat, core_rpt_edge} = '0;
        core_op = op_data_read;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 3; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check_data(q, 32'h0);
        end
        apb(1'b0, 12'h010, 32'h0);
        check_data(32'(err), 32'h1);
        apb(1'b1, OFS_CORE_CONTROL, 32'hffffffff);
        apb(1'b0, OFS_CORE_CONTROL, 32'h0);
        check_data(q, 32'h4);
        for (i = 0; i < 48; i++) begin
            rnd = lfsr_next(rnd);
            pg = (i == 0) ? 8'h80 : rnd[7:0];
            apb(1'b1, OFS_TABLE_PAGE, 32'(pg));
            apb(1'b0, OFS_TABLE_PAGE, 32'h0);
            check_data(q, 32'(pg));
            rnd = lfsr_next(rnd);
            ea = (i == 1) ? 16'hffff : rnd ^ {rnd[7:0], rnd[15:8]};
            b = rnd[3];
            ea[0] = ea[0] & b;
            op = op_e'(3'(1 + i % 4));
            run(op, b, ea, ~rnd);
            w = {pg, ea[15:1], 1'b0};
            check_data(32'(fa), 32'(w));
            check_data(32'(fc), 32'(pg[7]));
            check_data(32'(core_window_hit), 32'h0);
            if (op == op_table_read_low || op == op_table_read_high) begin
                w = word_at(w);
                m = (op == op_table_read_low)
                    ? (!b ? w[15:0] : {8'h00, ea[0] ? w[15:8] : w[7:0]})
                    : ((b && ea[0]) ? 16'h0000 : {8'h00, w[23:16]});
                check_data(32'(core_rdata & (b ? 16'h00ff : 16'hffff)),
                           32'(m));
                check_lat(n, 4);
            end else begin
                xbe = (op == op_table_write_low)
                      ? (!b ? BE_WORD : (ea[0] ? BE_MID : BE_LOW))
                      : ((b && ea[0]) ? BE_NONE : BE_HIGH);
                check_data(32'(be), 32'(xbe));
                w = (op == op_table_write_low)
                    ? (b ? {8'h00, ~rnd[7:0], ~rnd[7:0]} : {8'h00, ~rnd})
                    : {~rnd[7:0], 16'h0000};
                m = {{8{xbe[1]}}, {8{xbe[0]}}};
                check_data(32'(fw & {{8{xbe[2]}}, m}),
                           32'(w & {{8{xbe[2]}}, m}));
                check_lat(n, 3);
            end
        end
        for (i = 0; i < 32; i++) begin
            rnd = lfsr_next(rnd);
            pg = rnd[15:8];
            apb(1'b1, OFS_WINDOW_PAGE, 32'(pg));
            apb(1'b1, OFS_CORE_CONTROL, 32'({i % 5 != 4, 2'b00}));
            ea = {i % 7 != 6, rnd[14:1], 1'b0};
            hit = (i % 5 != 4) && ea[15];
            core_copy <= rnd[0];
            core_in_repeat <= rnd[1];
            core_rpt_edge <= rnd[2];
            ex = !rnd[1] ? (rnd[0] ? EXTRA_COPY : EXTRA_FULL)
                         : (rnd[2] ? EXTRA_FULL : EXTRA_NONE);
            run(op_data_read, 1'b0, ea, 16'h0000);
            w = word_at({1'b0, pg, ea[14:0]});
            check_data(32'(core_window_hit), 32'(hit));
            check_data(32'(core_rdata), hit ? 32'(w[15:0]) : 32'h0);
            if (hit) begin
                check_data(32'(fa), 32'({1'b0, pg, ea[14:0]}));
                check_data(32'(nreq), 32'h2);
                check_data(32'(core_extra), 32'(ex));
            end
            check_lat(n, !hit ? 3 : (ex == EXTRA_FULL ? 6 : 5));
        end
        print_verdict();
    end

    initial begin
        #400000;
        failures++;
        print_verdict();
    end
endmodule : program_space_data_access_test
`default_nettype wire
